/* pkg/mbps_pkg.sv */
/*
 Constants, types and the strap decoder of the module boot and power
 sequencer. Assumes a 125 MHz always-on clock and carrier pins that
 are active low, idle high when floating.
*/
package mbps_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CNT_W = 32;

	// Power-off hold time and its cycle count
	localparam int unsigned POWER_OFF_HOLD_S = 5;
	localparam int unsigned POWER_OFF_HOLD_CYCLES =
		POWER_OFF_HOLD_S * CLK_HZ;

	// Settle time for each supply stage
	localparam int unsigned SETTLE_TIME_US = 1000;
	localparam int unsigned SETTLE_CYCLES =
		SETTLE_TIME_US * (CLK_HZ / 1_000_000);

	// Glitch filter: input must stand this long to count
	localparam int unsigned FILTER_TIME_NS = 128;
	localparam int unsigned FILTER_CYCLES =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Bit positions of the carrier inputs in the filtered vector
	localparam int unsigned IN_SUPPLY_NG = 0;
	localparam int unsigned IN_RESET_REQ = 1;
	localparam int unsigned IN_BUTTON = 2;
	localparam int unsigned IN_RECOVERY = 3;
	localparam int unsigned IN_STRAP_LSB = 4;
	localparam int unsigned NUM_IN = 7;
	// Supply reads bad at reset, every other input idle high
	localparam logic [NUM_IN-1:0] IN_RESET_VAL = 7'h7E;

	// Strap pin patterns, bit i is strap i, float reads 1
	localparam logic [2:0] STRAP_FUSE_FLASH = 3'h7;
	localparam logic [2:0] STRAP_SPI_FLASH = 3'h1;
	localparam logic [2:0] STRAP_SD = 3'h4;
	localparam logic [2:0] STRAP_EMMC = 3'h5;
	localparam logic [2:0] STRAP_SERIAL_DL = 3'h6;

	localparam int unsigned FUSE_W = 2;

	typedef enum logic [2:0] {
		BOOT_FUSE_FLASH,
		BOOT_SPI_FLASH,
		BOOT_SD,
		BOOT_EMMC,
		BOOT_SERIAL_DL
	} mbps_boot_src_t;

	typedef enum logic [2:0] {
		ST_NO_SUPPLY,
		ST_INT_POWER,
		ST_CARRIER_POWER,
		ST_BOOT_HOLD,
		ST_RUN,
		ST_POWERED_OFF
	} mbps_state_t;

	// Unlisted patterns fall back to the fuse-selected flash
	function automatic mbps_boot_src_t mbps_decode_strap(
		input logic [2:0] strap,
		input logic recovery_b
	);
		mbps_boot_src_t src;
		src = BOOT_FUSE_FLASH;
		if (!recovery_b) begin
			src = BOOT_SERIAL_DL;
		end else if (strap == STRAP_SPI_FLASH) begin
			src = BOOT_SPI_FLASH;
		end else if (strap == STRAP_SD) begin
			src = BOOT_SD;
		end else if (strap == STRAP_EMMC) begin
			src = BOOT_EMMC;
		end else if (strap == STRAP_SERIAL_DL) begin
			src = BOOT_SERIAL_DL;
		end
		return src;
	endfunction
endpackage

/* pkg/mbps_sync_if.sv */
/*
 Carrier of the filtered carrier inputs from the input filter to the
 sequencer. Assumes both ends run on the same always-on clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mbps_sync_if #(
	parameter int unsigned N = 7
);
	logic [N-1:0] level;

	modport filt (output level);
	modport seq (input level);
endinterface
`default_nettype wire

/* rtl/mbps_in_filter.sv */
/*
 Two-flop synchroniser and stability filter for each carrier input.
 Assumes raw inputs may change at any time relative to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module mbps_in_filter
	import mbps_pkg::*;
#(
	parameter int unsigned N = NUM_IN,
	parameter int unsigned STABLE = FILTER_CYCLES,
	parameter logic [N-1:0] RST_VAL = IN_RESET_VAL
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [N-1:0] raw_i,
	mbps_sync_if.filt out
);
	localparam logic [7:0] LAST = 8'(STABLE - 1);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			logic filt_reg;
			logic filt_next;
			logic [7:0] cnt_reg;
			logic [7:0] cnt_next;

			// A change must stand STABLE cycles before it is passed on
			always_comb begin
				filt_next = filt_reg;
				cnt_next = 8'h00;
				if (sync_reg != filt_reg) begin
					if (cnt_reg == LAST) begin
						filt_next = sync_reg;
					end else begin
						cnt_next = cnt_reg + 8'h01;
					end
				end
			end

			always_ff @(posedge mclk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_reg <= RST_VAL[g];
					sync_reg <= RST_VAL[g];
					filt_reg <= RST_VAL[g];
					cnt_reg <= 8'h00;
				end else begin
					meta_reg <= raw_i[g];
					sync_reg <= meta_reg;
					filt_reg <= filt_next;
					cnt_reg <= cnt_next;
				end
			end

			assign out.level[g] = filt_reg;
		end
	endgenerate
endmodule
`default_nettype wire

/* rtl/mbps_seq_top.sv */
/*
 Module boot and power sequencer: brings up internal and carrier
 power, holds boot until the carrier is ready, latches the boot
 source and handles the power button. Assumes an always-on clock
 and that the carrier drives its inputs at board level.
*/
`timescale 1ns/1ps
`default_nettype none
module mbps_seq_top
	import mbps_pkg::*;
#(
	parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
	parameter int unsigned HOLD_OFF_CNT = POWER_OFF_HOLD_CYCLES,
	parameter int unsigned FW = FUSE_W
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic input_supply_not_good_b_i,
	input wire logic external_reset_request_b_i,
	input wire logic wake_button_input_b_i,
	input wire logic recovery_override_b_i,
	input wire logic [2:0] boot_strap_b_i,
	input wire logic [FW-1:0] fuse_flash_if_sel_i,
	output logic internal_power_enable_o,
	output logic downstream_supply_enable_o,
	output logic downstream_suspend_indication_b_o,
	output logic boot_hold_output_b_o,
	output var mbps_boot_src_t boot_source_o,
	output logic [FW-1:0] flash_if_sel_o,
	output logic usb_download_enable_o,
	output logic powered_off_o
);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CNT - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_OFF_CNT - 1);

	mbps_sync_if #(.N(NUM_IN)) sync_bus ();

	// All carrier pins but fuse_flash_if_sel_i pass the filter before any logic sees them
	mbps_in_filter #(
		.N(NUM_IN),
		.STABLE(FILTER_CYCLES),
		.RST_VAL(IN_RESET_VAL)
	) u_filter (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.raw_i({boot_strap_b_i, recovery_override_b_i,
			wake_button_input_b_i, external_reset_request_b_i,
			input_supply_not_good_b_i}),
		.out(sync_bus.filt)
	);

	logic supply_good;
	logic reset_req;
	logic btn_pressed;
	logic recovery_b;
	logic [2:0] strap;

	// supply not good read as active low
	assign supply_good = sync_bus.level[IN_SUPPLY_NG];
	assign reset_req = !sync_bus.level[IN_RESET_REQ];
	assign btn_pressed = !sync_bus.level[IN_BUTTON];
	assign recovery_b = sync_bus.level[IN_RECOVERY];
	assign strap = sync_bus.level[IN_STRAP_LSB +: 3];

	mbps_state_t state_reg;
	mbps_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] hold_cnt_reg;
	logic [CNT_W-1:0] hold_cnt_next;
	logic btn_prev_reg;
	logic btn_prev_next;
	logic off_latched_reg;
	logic off_latched_next;
	logic hold_expired;
	logic btn_edge;
	logic powered;

	assign powered = (state_reg == ST_INT_POWER) ||
		(state_reg == ST_CARRIER_POWER) ||
		(state_reg == ST_BOOT_HOLD) || (state_reg == ST_RUN);
	assign btn_edge = btn_pressed && !btn_prev_reg;
	// five seconds of steady press counted
	assign hold_expired = btn_pressed && (hold_cnt_reg == HOLD_LAST);

	// Button hold counter runs only while pressed and powered
	always_comb begin
		btn_prev_next = btn_pressed;
		hold_cnt_next = {CNT_W{1'b0}};
		if (btn_pressed && powered && !hold_expired) begin
			hold_cnt_next = hold_cnt_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			btn_prev_reg <= 1'b0;
			hold_cnt_reg <= {CNT_W{1'b0}};
		end else begin
			btn_prev_reg <= btn_prev_next;
			hold_cnt_reg <= hold_cnt_next;
		end
	end

	// Sequencer next state; supply loss overrides every state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		off_latched_next = off_latched_reg;
		if (!supply_good) begin
			state_next = ST_NO_SUPPLY;
			cnt_next = {CNT_W{1'b0}};
		end else if (powered && hold_expired) begin
			state_next = ST_POWERED_OFF;
			off_latched_next = 1'b1;
			cnt_next = {CNT_W{1'b0}};
		end else begin
			case (state_reg)
				ST_NO_SUPPLY: begin
					if (off_latched_reg) begin
						state_next = ST_POWERED_OFF;
					end else begin
						state_next = ST_INT_POWER;
					end
					cnt_next = {CNT_W{1'b0}};
				end
				ST_INT_POWER: begin
					if (cnt_reg == SETTLE_LAST) begin
						state_next = ST_CARRIER_POWER;
						cnt_next = {CNT_W{1'b0}};
					end else begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
				ST_CARRIER_POWER: begin
					if (cnt_reg == SETTLE_LAST) begin
						state_next = ST_BOOT_HOLD;
						cnt_next = {CNT_W{1'b0}};
					end else begin
						cnt_next = cnt_reg + CNT_W'(1);
					end
				end
				ST_BOOT_HOLD: begin
					if (!reset_req) begin
						state_next = ST_RUN;
					end
				end
				ST_RUN: begin
					if (reset_req) begin
						state_next = ST_BOOT_HOLD;
					end
				end
				ST_POWERED_OFF: begin
					if (btn_edge) begin
						state_next = ST_INT_POWER;
						off_latched_next = 1'b0;
						cnt_next = {CNT_W{1'b0}};
					end
				end
				default: begin
					state_next = ST_NO_SUPPLY;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_NO_SUPPLY;
			cnt_reg <= {CNT_W{1'b0}};
			off_latched_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			off_latched_reg <= off_latched_next;
		end
	end

	logic int_pwr_reg;
	logic int_pwr_next;
	logic sup_en_reg;
	logic sup_en_next;
	logic susp_b_reg;
	logic susp_b_next;
	logic hold_b_reg;
	logic hold_b_next;
	logic off_reg;
	logic off_next;

	// Outputs decoded from the next state so they leave flip-flops
	// in step with the state register
	always_comb begin
		int_pwr_next = 1'b0;
		sup_en_next = 1'b0;
		susp_b_next = 1'b0;
		hold_b_next = 1'b0;
		off_next = 1'b0;
		case (state_next)
			ST_INT_POWER: begin
				int_pwr_next = 1'b1;
			end
			ST_CARRIER_POWER, ST_BOOT_HOLD: begin
				// carrier power up, out of suspend
				int_pwr_next = 1'b1;
				sup_en_next = 1'b1;
				susp_b_next = 1'b1;
			end
			ST_RUN: begin
				int_pwr_next = 1'b1;
				sup_en_next = 1'b1;
				susp_b_next = 1'b1;
				hold_b_next = 1'b1;
			end
			ST_POWERED_OFF: begin
				off_next = 1'b1;
			end
			default: begin
				off_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_pwr_reg <= 1'b0;
			sup_en_reg <= 1'b0;
			susp_b_reg <= 1'b0;
			hold_b_reg <= 1'b0;
			off_reg <= 1'b0;
		end else begin
			int_pwr_reg <= int_pwr_next;
			sup_en_reg <= sup_en_next;
			susp_b_reg <= susp_b_next;
			hold_b_reg <= hold_b_next;
			off_reg <= off_next;
		end
	end

	mbps_boot_src_t src_reg;
	mbps_boot_src_t src_next;
	logic [FW-1:0] fuse_reg;
	logic [FW-1:0] fuse_next;
	logic usb_dl_reg;
	logic usb_dl_next;
	logic capture;

	// Straps change only when boot hold is lifted, so a strap moved
	// during run has no effect until the next release
	assign capture = (state_reg == ST_BOOT_HOLD) &&
		(state_next == ST_RUN);

	always_comb begin
		src_next = src_reg;
		fuse_next = fuse_reg;
		usb_dl_next = usb_dl_reg;
		if (capture) begin
			src_next = mbps_decode_strap(strap, recovery_b);
			fuse_next = fuse_flash_if_sel_i;
			// serial download uses primary USB port
			usb_dl_next = (mbps_decode_strap(strap, recovery_b) ==
				BOOT_SERIAL_DL);
		end else if (state_next != ST_RUN) begin
			usb_dl_next = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			src_reg <= BOOT_FUSE_FLASH;
			fuse_reg <= {FW{1'b0}};
			usb_dl_reg <= 1'b0;
		end else begin
			src_reg <= src_next;
			fuse_reg <= fuse_next;
			usb_dl_reg <= usb_dl_next;
		end
	end

	assign internal_power_enable_o = int_pwr_reg;
	assign downstream_supply_enable_o = sup_en_reg;
	assign downstream_suspend_indication_b_o = susp_b_reg;
	assign boot_hold_output_b_o = hold_b_reg;
	assign boot_source_o = src_reg;
	assign flash_if_sel_o = fuse_reg;
	assign usb_download_enable_o = usb_dl_reg;
	assign powered_off_o = off_reg;
endmodule
`default_nettype wire

/* tb/mbps_carrier_model.sv */
/*
 Carrier board power and reset logic model: turns the bench's plain
 commands into carrier pin levels, one clock after each command; supply good rises RAIL_STABLE + 1 clocks after rail on.
 Assumes the bench drives its command inputs on rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mbps_carrier_model #(
	parameter int unsigned RAIL_STABLE = 3
) (
	input wire logic mclk_i,
	input wire logic rail_on_i,
	input wire logic hold_boot_i,
	input wire logic press_i,
	input wire logic force_dl_i,
	input wire logic [2:0] strap_i,
	input wire logic [1:0] fuse_i,
	output logic supply_b_o,
	output logic reset_req_b_o,
	output logic button_b_o,
	output logic recovery_b_o,
	output logic [2:0] strap_b_o,
	output logic [1:0] fuse_o
);
	int rail_cnt = 0;

	// Pins follow the commands one edge later, as board logic would
	always @(posedge mclk_i) begin
		// supply reads bad until the rail has stood stable
		if (!rail_on_i) begin
			rail_cnt <= 0;
			supply_b_o <= 1'b0;
		end else if (rail_cnt < RAIL_STABLE) begin
			rail_cnt <= rail_cnt + 1;
			supply_b_o <= 1'b0;
		end else begin
			supply_b_o <= 1'b1;
		end
		reset_req_b_o <= !hold_boot_i;
		button_b_o <= !press_i;
		// override kept high unless download is wanted
		recovery_b_o <= !force_dl_i;
		strap_b_o <= strap_i;
		fuse_o <= fuse_i;
	end
endmodule
`default_nettype wire

/* tb/mbps_seq_monitor.sv */
/*
 Port checker of the boot and power sequencer.
 Assumes a bind to mbps_seq_top with the short sim settle count.
*/
`timescale 1ns/1ps
`default_nettype none
module mbps_seq_monitor
	import mbps_pkg::*;
#(
	parameter int unsigned SETTLE_CNT = 4
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic input_supply_not_good_b_i,
	input wire logic external_reset_request_b_i,
	input wire logic internal_power_enable_o,
	input wire logic downstream_supply_enable_o,
	input wire logic downstream_suspend_indication_b_o,
	input wire logic boot_hold_output_b_o,
	input wire mbps_boot_src_t boot_source_o,
	input wire logic usb_download_enable_o,
	input wire logic powered_off_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	// Long low runs outlast the input filter latency
	a_carrier_needs_int: assert property (
		downstream_supply_enable_o |-> internal_power_enable_o)
		else $error("carrier power without internal power");
	a_suspend_with_carrier: assert property (
		downstream_suspend_indication_b_o == downstream_supply_enable_o)
		else $error("suspend line disagrees with carrier power");
	a_hold_needs_carrier: assert property (
		boot_hold_output_b_o |-> downstream_supply_enable_o)
		else $error("boot released without carrier power");
	a_carrier_settle_time: assert property (
		$rose(downstream_supply_enable_o) |->
		$past(internal_power_enable_o, SETTLE_CNT) &&
		!$past(internal_power_enable_o, SETTLE_CNT + 1))
		else $error("carrier power not one settle after internal");
	a_release_settle_time: assert property (
		$rose(boot_hold_output_b_o) |->
		$past(downstream_supply_enable_o, SETTLE_CNT + 1))
		else $error("boot released too early");
	a_supply_loss_off: assert property (
		(!input_supply_not_good_b_i)[*8] ##1
		(!input_supply_not_good_b_i)[*8] ##1
		(!input_supply_not_good_b_i)[*8] |->
		!internal_power_enable_o && !boot_hold_output_b_o)
		else $error("power kept while supply bad");
	a_reset_req_holds: assert property (
		(!external_reset_request_b_i)[*8] ##1
		(!external_reset_request_b_i)[*8] ##1
		(!external_reset_request_b_i)[*8] |-> !boot_hold_output_b_o)
		else $error("boot runs during reset request");
	a_usb_in_download: assert property (
		usb_download_enable_o |-> boot_hold_output_b_o &&
		boot_source_o == BOOT_SERIAL_DL)
		else $error("usb download outside serial download");
	a_source_kept: assert property (
		boot_hold_output_b_o && $past(boot_hold_output_b_o) |->
		$stable(boot_source_o))
		else $error("boot source changed while running");
	a_off_all_dark: assert property (
		powered_off_o |-> !internal_power_enable_o &&
		!downstream_supply_enable_o && !boot_hold_output_b_o)
		else $error("power on in button off state");
endmodule

bind mbps_seq_top mbps_seq_monitor #(.SETTLE_CNT(SETTLE_CNT)) u_mon (
	.mclk_i(mclk_i),
	.rst_b_i(rst_b_i),
	.input_supply_not_good_b_i(input_supply_not_good_b_i),
	.external_reset_request_b_i(external_reset_request_b_i),
	.internal_power_enable_o(internal_power_enable_o),
	.downstream_supply_enable_o(downstream_supply_enable_o),
	.downstream_suspend_indication_b_o(downstream_suspend_indication_b_o),
	.boot_hold_output_b_o(boot_hold_output_b_o),
	.boot_source_o(boot_source_o),
	.usb_download_enable_o(usb_download_enable_o),
	.powered_off_o(powered_off_o)
);
`default_nettype wire

/* tb/mbps_seq_top_tb.sv */
/*
 Self-checking bench of the boot and power sequencer.
 Assumes short settle and hold counts so that the run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none
module mbps_seq_top_tb;
	import mbps_pkg::*;
	localparam int unsigned HOLD = 40;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic sup_b, req_b, btn_b, rec_b, ipe, dse, sus_b, hold_b, usb, poff;
	logic [2:0] strap_b;
	logic [1:0] fuse, fsel;
	mbps_boot_src_t src;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	// Commands to the carrier model
	logic rail = 1'b0;
	logic hold_boot = 1'b0;
	logic press_on = 1'b0;
	logic force_dl = 1'b0;
	logic [2:0] strap_cmd = 3'h7;
	logic [1:0] fuse_cmd = 2'h2;

	mbps_carrier_model u_car (
		.mclk_i(mclk_i),
		.rail_on_i(rail),
		.hold_boot_i(hold_boot),
		.press_i(press_on),
		.force_dl_i(force_dl),
		.strap_i(strap_cmd),
		.fuse_i(fuse_cmd),
		.supply_b_o(sup_b),
		.reset_req_b_o(req_b),
		.button_b_o(btn_b),
		.recovery_b_o(rec_b),
		.strap_b_o(strap_b),
		.fuse_o(fuse)
	);

	mbps_seq_top #(.SETTLE_CNT(4), .HOLD_OFF_CNT(HOLD)) u_mbps_seq_top (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.input_supply_not_good_b_i(sup_b),
		.external_reset_request_b_i(req_b),
		.wake_button_input_b_i(btn_b), .recovery_override_b_i(rec_b),
		.boot_strap_b_i(strap_b), .fuse_flash_if_sel_i(fuse),
		.internal_power_enable_o(ipe), .downstream_supply_enable_o(dse),
		.downstream_suspend_indication_b_o(sus_b),
		.boot_hold_output_b_o(hold_b), .boot_source_o(src),
		.flash_if_sel_o(fsel), .usb_download_enable_o(usb),
		.powered_off_o(poff));

	// Clock and a hang guard well past the expected run length
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic check(input string name, input logic [2:0] got,
		input logic [2:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Bounded wait so a stuck hold shows as a mismatch, not a hang
	task automatic wait_hold(input logic lvl);
		int n;
		n = 0;
		while (hold_b !== lvl && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		#1;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// Each command changes just after a rising edge
	task automatic set_rail(input logic on);
		@(posedge mclk_i);
		rail <= on;
	endtask

	task automatic set_req(input logic act);
		@(posedge mclk_i);
		hold_boot <= act;
	endtask

	task automatic set_straps(input logic [2:0] s, input logic fdl,
		input logic [1:0] f);
		@(posedge mclk_i);
		strap_cmd <= s;
		force_dl <= fdl;
		fuse_cmd <= f;
	endtask

	task automatic set_press(input logic on);
		@(posedge mclk_i);
		press_on <= on;
	endtask

	task automatic boot_one(input logic [2:0] s, input logic fdl,
		input logic [1:0] f, input logic [2:0] exp);
		set_straps(s, fdl, f);
		set_rail(1'b1);
		wait_hold(1'b1);
		check("carrier", {hold_b, dse, sus_b}, 3'h7);
		check("source", src, exp);
		check("usb", 3'(usb), 3'(exp == BOOT_SERIAL_DL));
		check("fuse sel", 3'(fsel), 3'(f));
		set_rail(1'b0);
		idle(30);
		check("off", {ipe, dse, hold_b}, 3'h0);
	endtask

	task automatic scen_boot_table();
		boot_one(3'h7, 1'b0, 2'h2, BOOT_FUSE_FLASH);
		boot_one(3'h1, 1'b0, 2'h1, BOOT_SPI_FLASH);
		boot_one(3'h4, 1'b0, 2'h3, BOOT_SD);
		boot_one(3'h5, 1'b0, 2'h0, BOOT_EMMC);
		boot_one(3'h6, 1'b0, 2'h2, BOOT_SERIAL_DL);
		boot_one(3'h4, 1'b1, 2'h1, BOOT_SERIAL_DL);
		boot_one(3'h0, 1'b0, 2'h3, BOOT_FUSE_FLASH);
	endtask

	task automatic scen_reset_req();
		set_straps(3'h5, 1'b0, 2'h2);
		set_req(1'b1);
		set_rail(1'b1);
		idle(100);
		check("postpone", {ipe, dse, hold_b}, 3'h6);
		set_straps(3'h4, 1'b0, 2'h2);
		set_req(1'b0);
		wait_hold(1'b1);
		check("late src", src, BOOT_SD);
		set_straps(3'h1, 1'b0, 2'h2);
		idle(30);
		check("kept src", src, BOOT_SD);
		set_req(1'b1);
		wait_hold(1'b0);
		check("reset in", {ipe, dse, hold_b}, 3'h6);
		set_req(1'b0);
		wait_hold(1'b1);
		check("new src", src, BOOT_SPI_FLASH);
		set_rail(1'b0);
		idle(30);
	endtask

	// Reset in mid-run drops every output, then power-up restarts
	task automatic scen_mid_reset();
		set_straps(3'h5, 1'b0, 2'h1);
		set_rail(1'b1);
		wait_hold(1'b1);
		check("pre reset", {hold_b, dse, ipe}, 3'h7);
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		#1;
		check("in reset", {ipe, dse, hold_b}, 3'h0);
		check("reset src", src, BOOT_FUSE_FLASH);
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		idle(2);
		check("after reset", {ipe, dse, sus_b}, 3'h0);
		wait_hold(1'b1);
		check("reboot src", src, BOOT_EMMC);
		check("reboot fuse", 3'(fsel), 3'h1);
		set_rail(1'b0);
		idle(30);
	endtask

	task automatic scen_button();
		set_straps(3'h7, 1'b0, 2'h2);
		set_rail(1'b1);
		wait_hold(1'b1);
		set_press(1'b1);
		idle(25);
		set_press(1'b0);
		idle(60);
		check("short press", {poff, dse, hold_b}, 3'h3);
		set_press(1'b1);
		idle(HOLD + 40);
		check("held off", {poff, ipe, hold_b}, 3'h4);
		idle(40);
		check("no rewake", {poff, ipe, hold_b}, 3'h4);
		set_press(1'b0);
		idle(30);
		set_press(1'b1);
		idle(30);
		set_press(1'b0);
		wait_hold(1'b1);
		check("wake", {poff, dse, hold_b}, 3'h3);
		set_rail(1'b0);
		idle(30);
	endtask

	// Reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		idle(5);
		scen_boot_table();
		scen_reset_req();
		scen_mid_reset();
		scen_button();
		test_done();
	end
endmodule
`default_nettype wire
